// ==== pkg/sms_pkg.sv ====
// Package for the step mode supervisor: constants, map and carriers
`default_nettype none
package sms_pkg;
   // Scan cycle timing
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned SCAN_TIME_US = 100;
   localparam int unsigned SCAN_CYC = SCAN_TIME_US * (CLK_HZ / 1000000);
   localparam int unsigned SCAN_CW = 16;

   // Widths
   localparam int unsigned STEP_W = 10;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned HIST_N = 8;

   // Reserved homing step range
   localparam logic [STEP_W-1:0] HOME_STEP_LO = 10'h00A;
   localparam logic [STEP_W-1:0] HOME_STEP_HI = 10'h013;

   // Register word addresses
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] AUTO_LOW_ADDR = 4'h1;
   localparam logic [ADDR_W-1:0] AUTO_HIGH_ADDR = 4'h2;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h3;
   localparam logic [ADDR_W-1:0] HIST_BASE_ADDR = 4'h8;

   // Control register fields
   localparam int unsigned CTRL_INIT_BIT = 0;
   localparam int unsigned CTRL_KEEP_BIT = 1;
   localparam int unsigned CTRL_MON_BIT = 2;

   // Reset values
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [STEP_W-1:0] AUTO_LOW_RST = 10'h014;
   localparam logic [STEP_W-1:0] AUTO_HIGH_RST = 10'h38F;

   // Operating modes, one-hot
   typedef enum logic [4:0] {
      SMS_MANUAL = 5'h01,
      SMS_HOMING = 5'h02,
      SMS_SINGLE = 5'h04,
      SMS_CYCLE = 5'h08,
      SMS_CONT = 5'h10
   } sms_mode_t;

   // Operator panel pins
   typedef struct packed {
      logic manual;
      logic homing;
      logic single;
      logic cycle;
      logic cont;
      logic home_start;
      logic auto_start;
      logic auto_stop;
      logic zero_point_condition;
      logic at_zero;
   } sms_panel_t;

   // Flags driven to the step sequence
   typedef struct packed {
      logic transition_inhibit;
      logic transition_start;
      logic start_pulse;
      logic homing_done;
      logic step_active_status;
      logic step_monitor_enable;
   } sms_flags_t;
endpackage
`default_nettype wire

// ==== rtl/sms_supervisor.sv ====
// Step mode supervisor: mode flags, mode change resets, step history
//
// Behaviour
// - Inhibit flag set blocks every step from advancing.
// - Manual mode keeps the inhibit flag set.
// - Homing and one-cycle: inhibit set from auto stop to auto start.
// - Single step: inhibit stays set until an auto start.
// - Continuous: inhibit set entering run, cleared by auto start; the code keeps the previous inhibit value on entry.
// - Manual and homing keep the start flag cleared.
// - Single step and one-cycle: auto start sets the start flag.
// - Continuous: start flag set on auto start, cleared on stop.
// - Each auto start gives one start pulse only; the code gives none in manual or homing mode.
// - Homing-done flag marks the end of the homing sequence.
// - Continuous: leaving auto initial step needs the zero-point flag.
// - Off zero, listed changes without keep: reset steps and outputs.
// - Same changes with keep set: reset step, keep outputs.
// - At zero, homing to manual: reset step, keep outputs.
// - Step-active flag set while monitor enable is set and any step is active.
// - Monitor keeps current plus seven previous active step numbers.
// - Running mode initialisation forces monitor enable every scan.
// - Initial steps zero, one, two enter manual, homing, auto.
// - Steps ten to nineteen reserved; homing refused while active.
// - Auto refused while homing done or auto range step active.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sms_supervisor (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire sms_pkg::sms_panel_t panel_i,
   input wire logic step_valid_i,
   input wire logic [sms_pkg::STEP_W-1:0] step_num_i,
   input wire logic homing_finish_i,
   input wire logic [sms_pkg::ADDR_W-1:0] addr_i,
   input wire logic [sms_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [sms_pkg::DATA_W-1:0] rdata_o,
   output sms_pkg::sms_flags_t flags_o,
   output logic [2:0] init_step_o,
   output logic step_reset_o,
   output logic output_reset_o,
   output logic scan_tick_o
);
   // Pin synchroniser; first stage read only by the second
   sms_pkg::sms_panel_t sync1_q;
   sms_pkg::sms_panel_t pin_q;
   sms_pkg::sms_panel_t pin_prev_q;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_q <= '0;
         pin_q <= '0;
         pin_prev_q <= '0;
      end else begin
         sync1_q <= panel_i;
         pin_q <= sync1_q;
         pin_prev_q <= pin_q;
      end
   end

   // Button edges
   wire logic start_edge = pin_q.auto_start & ~pin_prev_q.auto_start;
   wire logic stop_edge = pin_q.auto_stop & ~pin_prev_q.auto_stop;
   wire logic home_edge = pin_q.home_start & ~pin_prev_q.home_start;

   // Scan divider: one-cycle enable per scan
   logic [sms_pkg::SCAN_CW-1:0] scan_cnt_q;
   wire logic scan_tick =
      (scan_cnt_q == sms_pkg::SCAN_CW'(sms_pkg::SCAN_CYC - 1));
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scan_cnt_q <= '0;
      end else begin
         scan_cnt_q <= scan_tick ? '0 : scan_cnt_q + 1'b1;
      end
   end

   // Software registers
   logic [2:0] ctrl_q;
   logic [sms_pkg::STEP_W-1:0] auto_low_q;
   logic [sms_pkg::STEP_W-1:0] auto_high_q;
   wire logic init_run = ctrl_q[sms_pkg::CTRL_INIT_BIT];
   wire logic keep_outputs = ctrl_q[sms_pkg::CTRL_KEEP_BIT];
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_q <= sms_pkg::CTRL_RST;
         auto_low_q <= sms_pkg::AUTO_LOW_RST;
         auto_high_q <= sms_pkg::AUTO_HIGH_RST;
      end else if (wr_i) begin
         if (addr_i == sms_pkg::CTRL_ADDR) ctrl_q <= wdata_i[2:0];
         if (addr_i == sms_pkg::AUTO_LOW_ADDR)
            auto_low_q <= wdata_i[sms_pkg::STEP_W-1:0];
         if (addr_i == sms_pkg::AUTO_HIGH_ADDR)
            auto_high_q <= wdata_i[sms_pkg::STEP_W-1:0];
      end
   end

   // Range test, used for homing and auto ranges
   function automatic logic in_range(input logic [sms_pkg::STEP_W-1:0] n,
                                     input logic [sms_pkg::STEP_W-1:0] lo,
                                     input logic [sms_pkg::STEP_W-1:0] hi);
      in_range = (n >= lo) && (n <= hi);
   endfunction

   // Per-scan gathering of step activity reported by the sequence
   wire logic cur_home = step_valid_i &&
      in_range(step_num_i, sms_pkg::HOME_STEP_LO, sms_pkg::HOME_STEP_HI);
   wire logic cur_auto = step_valid_i &&
      in_range(step_num_i, auto_low_q, auto_high_q);
   logic acc_any_q;
   logic acc_home_q;
   logic acc_auto_q;
   logic [sms_pkg::STEP_W-1:0] acc_last_q;
   // Totals of the scan ending now, so a tick never acts a scan late
   wire logic scan_any = acc_any_q | step_valid_i;
   wire logic scan_home = acc_home_q | cur_home;
   wire logic scan_auto = acc_auto_q | cur_auto;
   wire logic [sms_pkg::STEP_W-1:0] last_d =
      step_valid_i ? step_num_i : acc_last_q;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acc_any_q <= 1'b0;
         acc_home_q <= 1'b0;
         acc_auto_q <= 1'b0;
         acc_last_q <= '0;
      end else begin
         acc_any_q <= scan_any & ~scan_tick;
         acc_home_q <= scan_home & ~scan_tick;
         acc_auto_q <= scan_auto & ~scan_tick;
         acc_last_q <= last_d;
      end
   end

   // Buttons held pending until the scan uses them; a press wins
   logic start_pend_q;
   logic stop_pend_q;
   logic home_pend_q;
   wire logic start_evt = start_pend_q | start_edge;
   wire logic stop_evt = stop_pend_q | stop_edge;
   wire logic home_evt = home_pend_q | home_edge;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         start_pend_q <= 1'b0;
         stop_pend_q <= 1'b0;
         home_pend_q <= 1'b0;
      end else begin
         start_pend_q <= start_evt & ~scan_tick;
         stop_pend_q <= stop_evt & ~scan_tick;
         home_pend_q <= home_evt & ~scan_tick;
      end
   end

   // Mode select, manual has priority over the other switches
   sms_pkg::sms_mode_t mode_q;
   wire sms_pkg::sms_mode_t mode_d =
      pin_q.manual ? sms_pkg::SMS_MANUAL :
      pin_q.homing ? sms_pkg::SMS_HOMING :
      pin_q.single ? sms_pkg::SMS_SINGLE :
      pin_q.cycle ? sms_pkg::SMS_CYCLE :
      pin_q.cont ? sms_pkg::SMS_CONT : mode_q;
   wire logic was_auto = (mode_q == sms_pkg::SMS_SINGLE) ||
      (mode_q == sms_pkg::SMS_CYCLE) || (mode_q == sms_pkg::SMS_CONT);
   wire logic now_auto = (mode_d == sms_pkg::SMS_SINGLE) ||
      (mode_d == sms_pkg::SMS_CYCLE) || (mode_d == sms_pkg::SMS_CONT);
   wire logic now_manual = (mode_d == sms_pkg::SMS_MANUAL);
   wire logic now_homing = (mode_d == sms_pkg::SMS_HOMING);

   // Mode change classes
   wire logic chg_reset = ~pin_q.at_zero &&
      (((mode_q == sms_pkg::SMS_MANUAL) && now_homing) ||
       (was_auto && (now_manual || now_homing)));
   wire logic chg_home_man = pin_q.at_zero &&
      (mode_q == sms_pkg::SMS_HOMING) && now_manual;

   // Initial step gating
   wire logic homing_allowed = ~scan_home;
   wire logic auto_allowed = ~flags_o.homing_done & ~scan_auto;

   // Next flag values, evaluated at the scan tick
   logic inhibit_d;
   logic tstart_d;
   logic zpc_gate;
   always_comb begin
      inhibit_d = flags_o.transition_inhibit;
      tstart_d = flags_o.transition_start;
      unique case (mode_d)
         sms_pkg::SMS_MANUAL: begin
            inhibit_d = 1'b1;
            tstart_d = 1'b0;
         end
         sms_pkg::SMS_HOMING: begin
            if (stop_evt) inhibit_d = 1'b1;
            if (start_evt) inhibit_d = 1'b0;
            tstart_d = 1'b0;
         end
         sms_pkg::SMS_SINGLE: begin
            // One scan of release per press keeps single stepping
            inhibit_d = ~start_evt;
            tstart_d = start_evt;
         end
         sms_pkg::SMS_CYCLE: begin
            if (stop_evt) inhibit_d = 1'b1;
            if (start_evt) inhibit_d = 1'b0;
            tstart_d = start_evt;
         end
         sms_pkg::SMS_CONT: begin
            if (start_evt) inhibit_d = 1'b0;
            if (start_evt) tstart_d = 1'b1;
            else if (stop_evt) tstart_d = 1'b0;
         end
      endcase
   end

   // Continuous mode leaves the auto initial step only on zero-point
   always_comb begin
      zpc_gate = (mode_d != sms_pkg::SMS_CONT) ||
         pin_q.zero_point_condition;
   end

   // Mode flags, set only at the scan tick; the start pulse clears one clock later
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_q <= sms_pkg::SMS_MANUAL;
         flags_o.transition_inhibit <= 1'b1;
         flags_o.transition_start <= 1'b0;
         flags_o.start_pulse <= 1'b0;
      end else if (scan_tick) begin
         mode_q <= mode_d;
         flags_o.transition_inhibit <= inhibit_d;
         flags_o.transition_start <= tstart_d & zpc_gate;
         flags_o.start_pulse <= start_evt & now_auto;
      end else begin
         flags_o.start_pulse <= 1'b0; // One clock only
      end
   end

   // Homing completion; the finish pulse wins over a new homing start
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_o.homing_done <= 1'b0;
      end else if (homing_finish_i) begin
         flags_o.homing_done <= 1'b1;
      end else if (home_evt && scan_tick && now_homing) begin
         flags_o.homing_done <= 1'b0;
      end
   end

   // Monitor enable and step activity
   wire logic mon_d = init_run | ctrl_q[sms_pkg::CTRL_MON_BIT];
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_o.step_monitor_enable <= 1'b0;
         flags_o.step_active_status <= 1'b0;
      end else if (scan_tick) begin
         flags_o.step_monitor_enable <= mon_d;
         flags_o.step_active_status <=
            (init_run | mon_d) & scan_any;
      end
   end

   // Initial steps and mode change resets; resets last one cycle
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_step_o <= 3'h0;
         step_reset_o <= 1'b0;
         output_reset_o <= 1'b0;
      end else if (scan_tick && init_run) begin
         init_step_o <= {now_auto & auto_allowed,
                         now_homing & homing_allowed,
                         now_manual};
         step_reset_o <= chg_reset | chg_home_man;
         output_reset_o <= chg_reset & ~keep_outputs;
      end else begin
         step_reset_o <= 1'b0;
         output_reset_o <= 1'b0;
         if (!init_run) init_step_o <= 3'h0;
      end
   end

   // Step history, newest in entry zero
   logic [sms_pkg::STEP_W-1:0] hist_q [sms_pkg::HIST_N];
   wire logic hist_push = scan_tick && mon_d &&
      scan_any && (last_d != hist_q[0]);
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hist_q[0] <= '0;
      end else if (hist_push) begin
         hist_q[0] <= last_d;
      end
   end
   genvar g;
   generate
      for (g = 1; g < sms_pkg::HIST_N; g++) begin : g_hist
         always_ff @(posedge clock_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               hist_q[g] <= '0;
            end else if (hist_push) begin
               hist_q[g] <= hist_q[g-1];
            end
         end
      end
   endgenerate

   // Read decode; unmapped addresses read zero
   localparam int unsigned DW_LOCAL = sms_pkg::DATA_W;
   wire logic hist_sel = addr_i[3];
   wire logic [DW_LOCAL-1:0] rd_mux =
      hist_sel ? DW_LOCAL'(hist_q[addr_i[2:0]]) :
      (addr_i == sms_pkg::CTRL_ADDR) ? DW_LOCAL'(ctrl_q) :
      (addr_i == sms_pkg::AUTO_LOW_ADDR) ? DW_LOCAL'(auto_low_q) :
      (addr_i == sms_pkg::AUTO_HIGH_ADDR) ? DW_LOCAL'(auto_high_q) :
      (addr_i == sms_pkg::STATUS_ADDR) ?
         DW_LOCAL'({mode_q, init_step_o, flags_o}) : '0;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= rd_i ? rd_mux : '0;
      end
   end

   // Scan tick made visible to the step sequence
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) scan_tick_o <= 1'b0;
      else scan_tick_o <= scan_tick;
   end

   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   manual_inhibit_a: assert property (
      scan_tick && mode_d == sms_pkg::SMS_MANUAL |=>
      flags_o.transition_inhibit && !flags_o.transition_start)
      else $error("manual mode must inhibit");
   homing_start_a: assert property (
      scan_tick && mode_d == sms_pkg::SMS_HOMING |=>
      !flags_o.transition_start)
      else $error("homing mode must keep start clear");
   single_step_a: assert property (
      scan_tick && mode_d == sms_pkg::SMS_SINGLE && !start_evt |=>
      flags_o.transition_inhibit)
      else $error("single step released without start");
   cont_start_a: assert property (
      scan_tick && mode_d == sms_pkg::SMS_CONT && start_evt &&
      pin_q.zero_point_condition |=> flags_o.transition_start)
      else $error("continuous start not set");
   zero_gate_a: assert property (
      scan_tick && mode_d == sms_pkg::SMS_CONT &&
      !pin_q.zero_point_condition |=> !flags_o.transition_start)
      else $error("start set without zero-point");
   pulse_once_a: assert property (
      flags_o.start_pulse |-> ##1 !flags_o.start_pulse [*8])
      else $error("start pulse held too long");
   flag_scan_a: assert property (
      !$past(scan_tick) |-> $stable(flags_o.transition_inhibit))
      else $error("inhibit changed between scans");
   keep_out_a: assert property (
      scan_tick && init_run && chg_reset && keep_outputs |=>
      step_reset_o && !output_reset_o ##1 !step_reset_o)
      else $error("keep outputs not honoured");
   homing_done_a: assert property (
      homing_finish_i |=> flags_o.homing_done)
      else $error("homing done not set");
   auto_refuse_a: assert property (
      scan_tick && init_run && flags_o.homing_done |=> !init_step_o[2])
      else $error("auto entered while homing done");
endmodule
`default_nettype wire

// ==== verif/sms_far_side.sv ====
// Far side model: operator panel pins and a one-step sequence stub
`timescale 1ns/1ps
`default_nettype none
module sms_far_side (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic [4:0] mode_sel_i,
   input wire logic start_btn_i,
   input wire logic stop_btn_i,
   input wire logic zero_ok_i,
   input wire logic at_zero_i,
   input wire logic step_load_i,
   input wire logic [sms_pkg::STEP_W-1:0] step_load_num_i,
   input wire logic step_reset_i,
   input wire logic home_done_i,
   output sms_pkg::sms_panel_t panel_o,
   output logic step_valid_o,
   output logic [sms_pkg::STEP_W-1:0] step_num_o,
   output logic homing_finish_o
);
   logic active_q;
   logic [sms_pkg::STEP_W-1:0] num_q;

   // Panel wiring; zero-point level comes from the machine side
   assign panel_o = {mode_sel_i[0], mode_sel_i[1], mode_sel_i[2],
      mode_sel_i[3], mode_sel_i[4], 1'b0, start_btn_i, stop_btn_i,
      zero_ok_i, at_zero_i};
   // Homing finish is pulsed straight from the bench
   assign homing_finish_o = home_done_i;
   assign step_valid_o = active_q;
   // Idle bus shows inverted data so a stale value cannot pass
   assign step_num_o = active_q ? num_q : ~num_q;

   // Active step: loaded by the bench, dropped on a step reset
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         active_q <= 1'b0;
         num_q <= '0;
      end else if (step_reset_i) begin
         active_q <= 1'b0;
      end else if (step_load_i) begin
         active_q <= 1'b1;
         num_q <= step_load_num_i;
      end
   end
endmodule
`default_nettype wire

// ==== verif/sms_supervisor_bench.sv ====
// Self-checking bench for the step mode supervisor
`timescale 1ns/1ps
`default_nettype none
module sms_supervisor_bench;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   sms_pkg::sms_panel_t panel;
   logic step_valid;
   logic [sms_pkg::STEP_W-1:0] step_num;
   logic homing_finish;
   logic [sms_pkg::ADDR_W-1:0] addr = '0;
   logic [sms_pkg::DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [sms_pkg::DATA_W-1:0] rdata;
   sms_pkg::sms_flags_t flags;
   logic [2:0] init_step;
   logic step_reset;
   logic output_reset;
   logic scan_tick;
   logic [4:0] mode_sel = sms_pkg::SMS_MANUAL;
   logic start_btn = 1'b0;
   logic stop_btn = 1'b0;
   logic zero_ok = 1'b0;
   logic at_zero = 1'b1;
   logic load = 1'b0;
   logic home_done = 1'b0;
   logic [sms_pkg::STEP_W-1:0] load_num = '0;
   int fails = 0;
   int total_checks = 0;
   int sr_cnt = 0;
   int or_cnt = 0;
   int sp_cnt = 0;
   int sr0;
   int or0;
   int sp0;

   // 40 MHz clock
   always #12.5 clock = ~clock;

   sms_supervisor uut (.clock_i(clock), .arst_n_i(arst_n), .panel_i(panel),
      .step_valid_i(step_valid), .step_num_i(step_num),
      .homing_finish_i(homing_finish), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .flags_o(flags),
      .init_step_o(init_step), .step_reset_o(step_reset),
      .output_reset_o(output_reset), .scan_tick_o(scan_tick));

   sms_far_side far (.clock_i(clock), .arst_n_i(arst_n),
      .mode_sel_i(mode_sel), .start_btn_i(start_btn), .stop_btn_i(stop_btn),
      .zero_ok_i(zero_ok), .at_zero_i(at_zero), .step_load_i(load),
      .step_load_num_i(load_num), .step_reset_i(step_reset),
      .home_done_i(home_done),
      .panel_o(panel), .step_valid_o(step_valid), .step_num_o(step_num),
      .homing_finish_o(homing_finish));

   // Pulse counters, so a missed or doubled pulse shows up later
   always @(posedge clock) begin
      if (step_reset === 1'b1) sr_cnt++;
      if (output_reset === 1'b1) or_cnt++;
      if (flags.start_pulse === 1'b1) sp_cnt++;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got,
            exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %b want %b", $time, msg, got,
            exp);
      end
   endtask

   // One-cycle write strobe beside address and data
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_expect(input logic [3:0] a, input logic [15:0] exp,
      input string msg);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      cmp_word(rdata, exp, msg);
   endtask

   // Bounded wait for the next scan tick pulse
   task automatic wait_tick;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (scan_tick !== 1'b1 && n < 5000);
      if (scan_tick !== 1'b1) begin
         fails++;
         $display("unexpected at %0t: no scan tick", $time);
         tally_and_finish;
      end
   endtask

   // Main sequence: run, stop off zero, keep, single step, homing
   initial begin
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      #1;
      cmp_word({10'h000, flags}, 16'h0020, "flags after reset");
      cmp_word({13'h0000, init_step}, 16'h0000, "init step reset");
      rd_expect(sms_pkg::CTRL_ADDR, 16'h0000, "ctrl reset");
      rd_expect(sms_pkg::AUTO_LOW_ADDR, 16'h0014, "low reset");
      rd_expect(sms_pkg::AUTO_HIGH_ADDR, 16'h038F, "high reset");
      rd_expect(4'h4, 16'h0000, "unmapped read");
      rd_expect(sms_pkg::STATUS_ADDR, 16'h0220, "status reset");
      // Status is read-only; the write must leave it as it was
      reg_write(sms_pkg::STATUS_ADDR, 16'hFFFF);
      rd_expect(sms_pkg::STATUS_ADDR, 16'h0220, "status write");
      // Mode initialisation running plus software monitor enable
      reg_write(sms_pkg::CTRL_ADDR, 16'h0005);
      rd_expect(sms_pkg::CTRL_ADDR, 16'h0005, "ctrl readback");
      @(posedge clock);
      mode_sel <= sms_pkg::SMS_CONT;
      zero_ok <= 1'b1;
      load <= 1'b1;
      load_num <= 10'h019;
      @(posedge clock);
      load <= 1'b0;
      start_btn <= 1'b1;
      repeat (5) @(posedge clock);
      start_btn <= 1'b0;
      wait_tick;
      cmp_flag(flags.transition_inhibit, 1'b0, "inhibit cont");
      cmp_flag(flags.transition_start, 1'b1, "start cont");
      cmp_flag(flags.start_pulse, 1'b1, "pulse high");
      cmp_flag(flags.step_active_status, 1'b1, "step active");
      cmp_flag(flags.step_monitor_enable, 1'b1, "monitor on");
      cmp_flag(flags.homing_done, 1'b0, "homing done");
      cmp_word({13'h0000, init_step}, 16'h0000, "auto refused");
      @(posedge clock);
      #1;
      cmp_flag(flags.start_pulse, 1'b0, "pulse one clock");
      rd_expect(sms_pkg::STATUS_ADDR, 16'h2013, "status cont");
      rd_expect(sms_pkg::HIST_BASE_ADDR, 16'h0019, "history newest");
      // Stop and switch to manual while off the zero point
      sr0 = sr_cnt;
      or0 = or_cnt;
      sp0 = sp_cnt;
      @(posedge clock);
      mode_sel <= sms_pkg::SMS_MANUAL;
      at_zero <= 1'b0;
      stop_btn <= 1'b1;
      repeat (5) @(posedge clock);
      stop_btn <= 1'b0;
      wait_tick;
      cmp_flag(flags.transition_inhibit, 1'b1, "inhibit manual");
      cmp_flag(flags.transition_start, 1'b0, "start manual");
      cmp_word({13'h0000, init_step}, 16'h0001, "manual init");
      repeat (4) @(posedge clock);
      #1;
      cmp_word(16'(sr_cnt - sr0), 16'h0001, "step resets");
      cmp_word(16'(or_cnt - or0), 16'h0001, "output resets");
      cmp_word(16'(sp_cnt - sp0), 16'h0000, "no extra pulse");
      cmp_flag(step_valid, 1'b0, "step dropped");
      rd_expect(sms_pkg::HIST_BASE_ADDR, 16'h0019, "history held");
      // Keep set, homing finished: auto refused, then back to manual off zero
      reg_write(sms_pkg::CTRL_ADDR, 16'h0007);
      @(posedge clock);
      home_done <= 1'b1;
      mode_sel <= sms_pkg::SMS_CONT;
      @(posedge clock);
      home_done <= 1'b0;
      @(posedge clock);
      #1;
      cmp_flag(flags.homing_done, 1'b1, "homing done set");
      wait_tick;
      cmp_word({13'h0000, init_step}, 16'h0000, "no auto");
      cmp_flag(flags.transition_inhibit, 1'b1, "cont waits");
      sr0 = sr_cnt;
      or0 = or_cnt;
      @(posedge clock);
      mode_sel <= sms_pkg::SMS_MANUAL;
      wait_tick;
      repeat (2) @(posedge clock);
      #1;
      cmp_word(16'(sr_cnt - sr0), 16'h0001, "keep step reset");
      cmp_word(16'(or_cnt - or0), 16'h0000, "keep outputs");
      // Single step: one scan of release per start press
      @(posedge clock);
      mode_sel <= sms_pkg::SMS_SINGLE;
      start_btn <= 1'b1;
      repeat (5) @(posedge clock);
      start_btn <= 1'b0;
      wait_tick;
      cmp_flag(flags.transition_inhibit, 1'b0, "single go");
      cmp_flag(flags.transition_start, 1'b1, "single start");
      cmp_flag(flags.start_pulse, 1'b1, "single pulse");
      wait_tick;
      cmp_flag(flags.transition_inhibit, 1'b1, "single held");
      cmp_flag(flags.transition_start, 1'b0, "single stop");
      // At zero, homing back to manual keeps the outputs
      @(posedge clock);
      mode_sel <= sms_pkg::SMS_HOMING;
      at_zero <= 1'b1;
      wait_tick;
      cmp_flag(flags.transition_start, 1'b0, "homing start");
      cmp_word({13'h0000, init_step}, 16'h0002, "homing init");
      sr0 = sr_cnt;
      or0 = or_cnt;
      @(posedge clock);
      mode_sel <= sms_pkg::SMS_MANUAL;
      wait_tick;
      repeat (2) @(posedge clock);
      #1;
      cmp_word(16'(sr_cnt - sr0), 16'h0001, "home to manual");
      cmp_word(16'(or_cnt - or0), 16'h0000, "outputs kept");
      tally_and_finish;
   end
endmodule
`default_nettype wire
